// ---- core/srq_pkg.sv ----
// status reporting constants, command encodings and carrier types
//----------------------------------------------------------------------
// Functional notes
//----------------------------------------------------------------------
package srq_pkg;
  // status register indices
  localparam int unsigned NREG     = 4;
  localparam logic [1:0]  REG_OPER = 2'h0;
  localparam logic [1:0]  REG_QUES = 2'h1;
  localparam logic [1:0]  REG_POW  = 2'h2;
  localparam logic [1:0]  REG_SYNC = 2'h3;
  // bits that exist in each register, all others read zero
  localparam logic [15:0] MASK_OPER = 16'h0001;
  localparam logic [15:0] MASK_QUES = 16'h0E1C;
  localparam logic [15:0] MASK_POW  = 16'h0004;
  localparam logic [15:0] MASK_SYNC = 16'h000F;
  // field positions
  localparam int unsigned POW_IF_OVERLOAD = 2;
  localparam int unsigned QUES_POW_SUM    = 3;
  localparam int unsigned QUES_SYNC_SUM   = 11;
  localparam int unsigned STB_ERR         = 2;
  localparam int unsigned STB_QUES        = 3;
  localparam int unsigned STB_MAV         = 4;
  localparam int unsigned STB_ESB         = 5;
  localparam int unsigned STB_RQS         = 6;
  localparam int unsigned STB_OPER        = 7;
  localparam logic [7:0]  STB_SRQ_MASK    = 8'hBC;
  localparam int unsigned ESR_OPC         = 0;
  localparam int unsigned ESR_PON         = 7;
  // reset and preset values
  localparam logic [15:0] PTR_PRESET  = 16'hFFFF;
  localparam logic [15:0] NTR_PRESET  = 16'h0000;
  localparam logic [15:0] ZERO16      = 16'h0000;
  localparam logic [7:0]  ZERO8       = 8'h00;
  localparam logic [15:0] NO_ERR_CODE = 16'h0000;
  // command operations
  typedef enum logic [4:0] {
    OP_RD_COND, OP_RD_EVENT, OP_RD_ENABLE, OP_RD_PTR, OP_RD_NTR,
    OP_WR_ENABLE, OP_WR_PTR, OP_WR_NTR, OP_RD_STB, OP_RD_SRE,
    OP_WR_SRE, OP_RD_ESE, OP_WR_ESE, OP_RD_ESR, OP_RD_PPE, OP_WR_PPE,
    OP_RD_ERR, OP_STAT_PRESET, OP_CLS, OP_RST, OP_OPC, OP_NOP
  } srq_op_t;
  // one decoded command
  typedef struct packed {
    srq_op_t     op;
    logic [1:0]  sel;
    logic [15:0] data;
    logic        first;
  } srq_cmd_t;
  // one status register with all its parts
  typedef struct packed {
    logic [15:0] cond;
    logic [15:0] ptr;
    logic [15:0] ntr;
    logic [15:0] evt;
    logic [15:0] en;
  } srq_sreg_t;
endpackage

// ---- core/srq_status_reporting.sv ----
// status registers, status byte, service request and error queue
`timescale 1ns/1ps
`default_nettype none
module srq_status_reporting #(
  parameter int unsigned ERR_DEPTH = 8,
  parameter logic [7:0]  SAVED_SRE = 8'h00,
  parameter logic [7:0]  SAVED_ESE = 8'h00
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             resetn_i,
  input  wire logic             psc_i,
  // decoded commands
  input  wire logic             cmd_valid_i,
  input  wire srq_pkg::srq_cmd_t cmd_i,
  input  wire logic             dcl_i,
  input  wire logic             spoll_i,
  // instrument conditions
  input  wire logic [15:0]      oper_cond_i,
  input  wire logic [15:0]      ques_cond_i,
  input  wire logic             if_overload_i,
  input  wire logic [15:0]      sync_cond_i,
  input  wire logic [7:0]       esr_set_i,
  input  wire logic             settings_busy_i,
  input  wire logic             err_push_i,
  input  wire logic [15:0]      err_code_i,
  // answers
  input  wire logic             rsp_take_i,
  output logic                  rsp_valid_o,
  output logic [15:0]           rsp_data_o,
  output logic [7:0]            spoll_byte_o,
  output logic                  spoll_valid_o,
  output logic                  srq_o,
  output logic                  overload_display_label_o,
  output logic                  flush_o,
  output logic                  settings_reset_o
);
  localparam int unsigned AW = $clog2(ERR_DEPTH);
  localparam logic [15:0] ZERO = srq_pkg::ZERO16;
  localparam logic [15:0] MASKS [srq_pkg::NREG] = '{
    srq_pkg::MASK_OPER, srq_pkg::MASK_QUES,
    srq_pkg::MASK_POW, srq_pkg::MASK_SYNC};

  srq_pkg::srq_sreg_t sr_reg [srq_pkg::NREG];
  srq_pkg::srq_sreg_t sr_next [srq_pkg::NREG];
  logic [15:0] cond_in [srq_pkg::NREG];
  logic [srq_pkg::NREG-1:0] sum;
  logic [7:0]  sre_reg, sre_next, ese_reg, ese_next;
  logic [7:0]  esr_reg, esr_next, ppe_reg, ppe_next, stb_reg, stb_now;
  logic        opc_reg, opc_next, srq_now;
  logic        rsp_valid_reg, rsp_valid_next;
  logic [15:0] rsp_data_reg, rsp_data_next;
  logic [7:0]  spoll_reg;
  logic        spoll_valid_reg, flush_reg, sreset_reg, ovl_reg;
  logic [15:0] err_mem [ERR_DEPTH];
  logic [AW-1:0] err_rd_reg, err_rd_next, err_wr_reg, err_wr_next;
  logic [AW:0] err_cnt_reg, err_cnt_next;
  logic        fire, preset, cls, pop, push;

  // command decode
  assign fire   = cmd_valid_i;
  assign preset = fire && cmd_i.op == srq_pkg::OP_STAT_PRESET;
  assign cls    = fire && cmd_i.op == srq_pkg::OP_CLS;
  assign pop    = fire && cmd_i.op == srq_pkg::OP_RD_ERR
                  && err_cnt_reg != '0;
  assign push   = err_push_i && err_cnt_reg != (AW+1)'(ERR_DEPTH);

  // condition sources, lower summaries feed questionable
  always_comb begin
    cond_in[0] = oper_cond_i;
    cond_in[1] = ques_cond_i;
    cond_in[1][srq_pkg::QUES_POW_SUM]  = sum[srq_pkg::REG_POW];
    cond_in[1][srq_pkg::QUES_SYNC_SUM] = sum[srq_pkg::REG_SYNC];
    cond_in[2] = ZERO;
    cond_in[2][srq_pkg::POW_IF_OVERLOAD] = if_overload_i;
    cond_in[3] = sync_cond_i;
  end

  //--------------------------------------------------------------------
  // status registers
  //--------------------------------------------------------------------
  for (genvar g = 0; g < srq_pkg::NREG; g++) begin : g_sreg
    logic [15:0] m, cnew, rise, fall, nevt;
    logic        sel;
    assign m   = MASKS[g];
    assign sel = fire && cmd_i.sel == 2'(g);
    assign sum[g] = |(sr_reg[g].evt & sr_reg[g].en);
    // edge filter, event capture and part writes
    always_comb begin
      sr_next[g] = sr_reg[g];
      cnew = cond_in[g] & m;
      rise = cnew & ~sr_reg[g].cond;
      fall = ~cnew & sr_reg[g].cond;
      nevt = (rise & sr_reg[g].ptr) | (fall & sr_reg[g].ntr);
      sr_next[g].cond = cnew;
      if (cls || (sel && cmd_i.op == srq_pkg::OP_RD_EVENT)) begin
        sr_next[g].evt = ZERO;
      end
      sr_next[g].evt = (sr_next[g].evt | nevt) & m; // set wins
      if (sel && cmd_i.op == srq_pkg::OP_WR_ENABLE) begin
        sr_next[g].en = cmd_i.data & m;
      end
      if (sel && cmd_i.op == srq_pkg::OP_WR_PTR) begin
        sr_next[g].ptr = cmd_i.data & m;
      end
      if (sel && cmd_i.op == srq_pkg::OP_WR_NTR) begin
        sr_next[g].ntr = cmd_i.data & m;
      end
      if (preset) begin
        sr_next[g].ptr = srq_pkg::PTR_PRESET & m;
        sr_next[g].ntr = srq_pkg::NTR_PRESET;
        sr_next[g].en  = (g < 2) ? ZERO : m;
      end
    end
    // register the parts, power-on filters preset
    always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
        sr_reg[g].cond <= ZERO;
        sr_reg[g].ptr  <= srq_pkg::PTR_PRESET & m;
        sr_reg[g].ntr  <= srq_pkg::NTR_PRESET;
        sr_reg[g].evt  <= ZERO;
        sr_reg[g].en   <= (g < 2) ? ZERO : m;
      end else begin
        sr_reg[g] <= sr_next[g];
      end
    end
  end

  //--------------------------------------------------------------------
  // status byte and standard event register
  //--------------------------------------------------------------------
  always_comb begin
    stb_now = srq_pkg::ZERO8;
    stb_now[srq_pkg::STB_ERR]  = err_cnt_reg != '0;
    stb_now[srq_pkg::STB_QUES] = sum[srq_pkg::REG_QUES];
    stb_now[srq_pkg::STB_MAV]  = rsp_valid_reg;
    stb_now[srq_pkg::STB_ESB]  = |(esr_reg & ese_reg);
    stb_now[srq_pkg::STB_OPER] = sum[srq_pkg::REG_OPER];
    srq_now = |(stb_now & sre_reg & srq_pkg::STB_SRQ_MASK);
    stb_now[srq_pkg::STB_RQS]  = srq_now;
  end

  // masks, event register and completion tracking
  always_comb begin
    sre_next = sre_reg;
    ese_next = ese_reg;
    ppe_next = ppe_reg;
    esr_next = esr_reg;
    opc_next = opc_reg;
    if (fire && cmd_i.op == srq_pkg::OP_WR_SRE) sre_next = cmd_i.data[7:0];
    if (fire && cmd_i.op == srq_pkg::OP_WR_ESE) ese_next = cmd_i.data[7:0];
    if (fire && cmd_i.op == srq_pkg::OP_WR_PPE) ppe_next = cmd_i.data[7:0];
    if (cls || (fire && cmd_i.op == srq_pkg::OP_RD_ESR)) begin
      esr_next = srq_pkg::ZERO8;
      opc_next = 1'b0;
    end
    if (fire && cmd_i.op == srq_pkg::OP_OPC) opc_next = 1'b1;
    if (opc_reg && !settings_busy_i) begin
      esr_next[srq_pkg::ESR_OPC] = 1'b1;
      opc_next = 1'b0;
    end
    esr_next = esr_next | esr_set_i; // set wins over read clear
  end

  // power-on: flag at 1 clears request and event masks, at 0 loads saved ones; parallel poll mask always clears
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      sre_reg <= psc_i ? srq_pkg::ZERO8 : SAVED_SRE;
      ese_reg <= psc_i ? srq_pkg::ZERO8 : SAVED_ESE;
      ppe_reg <= srq_pkg::ZERO8;
      esr_reg <= 8'(1 << srq_pkg::ESR_PON);
      opc_reg <= 1'b0;
      stb_reg <= srq_pkg::ZERO8;
    end else begin
      sre_reg <= sre_next;
      ese_reg <= ese_next;
      ppe_reg <= ppe_next;
      esr_reg <= esr_next;
      opc_reg <= opc_next;
      stb_reg <= stb_now;
    end
  end

  //--------------------------------------------------------------------
  // error queue
  //--------------------------------------------------------------------
  always_comb begin
    err_rd_next  = err_rd_reg;
    err_wr_next  = err_wr_reg;
    err_cnt_next = err_cnt_reg;
    if (cls) begin
      err_rd_next  = '0;
      err_wr_next  = '0;
      err_cnt_next = '0;
    end else begin
      if (pop) err_rd_next = AW'((err_rd_reg + 1'b1) % ERR_DEPTH);
      if (push) err_wr_next = AW'((err_wr_reg + 1'b1) % ERR_DEPTH);
      err_cnt_next = err_cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // queue storage and pointers
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      err_rd_reg  <= '0;
      err_wr_reg  <= '0;
      err_cnt_reg <= '0;
    end else begin
      err_rd_reg  <= err_rd_next;
      err_wr_reg  <= err_wr_next;
      err_cnt_reg <= err_cnt_next;
      if (push && !cls) err_mem[err_wr_reg] <= err_code_i;
    end
  end

  //--------------------------------------------------------------------
  // output buffer, one answer deep
  //--------------------------------------------------------------------
  always_comb begin
    rsp_valid_next = rsp_valid_reg && !rsp_take_i;
    rsp_data_next  = rsp_data_reg;
    if (fire && cmd_i.first) rsp_valid_next = 1'b0;
    if (fire) begin
      rsp_valid_next = 1'b1;
      case (cmd_i.op)
        srq_pkg::OP_RD_COND:   rsp_data_next = sr_reg[cmd_i.sel].cond;
        srq_pkg::OP_RD_EVENT:  rsp_data_next = sr_reg[cmd_i.sel].evt;
        srq_pkg::OP_RD_ENABLE: rsp_data_next = sr_reg[cmd_i.sel].en;
        srq_pkg::OP_RD_PTR:    rsp_data_next = sr_reg[cmd_i.sel].ptr;
        srq_pkg::OP_RD_NTR:    rsp_data_next = sr_reg[cmd_i.sel].ntr;
        srq_pkg::OP_RD_STB:    rsp_data_next = {8'h00, stb_now};
        srq_pkg::OP_RD_SRE:    rsp_data_next = {8'h00, sre_reg};
        srq_pkg::OP_RD_ESE:    rsp_data_next = {8'h00, ese_reg};
        srq_pkg::OP_RD_ESR:    rsp_data_next = {8'h00, esr_reg};
        srq_pkg::OP_RD_PPE:    rsp_data_next = {8'h00, ppe_reg};
        srq_pkg::OP_RD_ERR:    rsp_data_next = pop ? err_mem[err_rd_reg]
                                               : srq_pkg::NO_ERR_CODE;
        default: begin
          rsp_valid_next = rsp_valid_reg && !rsp_take_i && !cmd_i.first;
        end
      endcase
    end
    if (dcl_i) rsp_valid_next = 1'b0;
  end

  // answer, poll byte and one-cycle pulses
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      rsp_valid_reg   <= 1'b0;
      rsp_data_reg    <= ZERO;
      spoll_reg       <= srq_pkg::ZERO8;
      spoll_valid_reg <= 1'b0;
      flush_reg       <= 1'b1;
      sreset_reg      <= 1'b0;
      ovl_reg         <= 1'b0;
    end else begin
      rsp_valid_reg   <= rsp_valid_next;
      rsp_data_reg    <= rsp_data_next;
      spoll_valid_reg <= spoll_i;
      if (spoll_i) spoll_reg <= stb_now;
      flush_reg       <= dcl_i;
      sreset_reg      <= fire && cmd_i.op == srq_pkg::OP_RST;
      ovl_reg         <=
        sr_reg[srq_pkg::REG_POW].cond[srq_pkg::POW_IF_OVERLOAD];
    end
  end

  assign rsp_valid_o              = rsp_valid_reg;
  assign rsp_data_o               = rsp_data_reg;
  assign spoll_byte_o             = spoll_reg;
  assign spoll_valid_o            = spoll_valid_reg;
  assign srq_o                    = stb_reg[srq_pkg::STB_RQS];
  assign overload_display_label_o = ovl_reg;
  assign flush_o                  = flush_reg;
  assign settings_reset_o         = sreset_reg;

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  AST_OVERLOAD: assert property (
    if_overload_i |=> ##1 overload_display_label_o)
    else $error("overload label not shown");
  AST_POW_UNUSED: assert property (
    (sr_reg[2].evt & ~srq_pkg::MASK_POW) == ZERO)
    else $error("unused power bit set");
  AST_EVT_CLEAR: assert property (
    fire && cmd_i.op == srq_pkg::OP_RD_EVENT && cmd_i.sel == 2'h2
    && !if_overload_i && !$past(if_overload_i)
    |=> sr_reg[2].evt == ZERO && rsp_valid_o)
    else $error("event part not cleared by read");
  AST_SRQ: assert property (
    srq_o |-> $past((stb_now & sre_reg & srq_pkg::STB_SRQ_MASK) != 8'h00))
    else $error("request without enabled cause");
  AST_ESB: assert property (
    (esr_reg & ese_reg) != 8'h00 && sre_reg[5] |=> srq_o)
    else $error("standard event did not raise request");
  AST_ERR_EMPTY: assert property (
    fire && cmd_i.op == srq_pkg::OP_RD_ERR && err_cnt_reg == '0
    |=> rsp_valid_o && rsp_data_o == 16'h0000)
    else $error("empty queue did not answer zero");
  AST_ERR_POP: assert property (
    pop && !err_push_i |=> err_cnt_reg == $past(err_cnt_reg) - 1'b1)
    else $error("error query did not remove one entry");
  AST_CLS: assert property (
    cls && !err_push_i |=> err_cnt_reg == '0 && esr_reg == $past(esr_set_i))
    else $error("clear status incomplete");
  AST_PRESET: assert property (
    preset |=> sr_reg[0].ptr == srq_pkg::MASK_OPER
    && sr_reg[3].ntr == ZERO && sr_reg[1].en == ZERO
    && sr_reg[3].en == srq_pkg::MASK_SYNC)
    else $error("preset values wrong");
  AST_DCL: assert property (
    dcl_i && !fire |=> flush_o && !rsp_valid_o && $stable(sre_reg))
    else $error("device clear altered status");
endmodule
`default_nettype wire

// ---- sim/srq_ctrl_model.sv ----
// remote controller model driving the command port
`timescale 1ns/1ps
`default_nettype none
module srq_ctrl_model (
  // clock and answers
  input  wire logic         clock_i,
  input  wire logic         rsp_valid_i,
  input  wire logic [15:0]  rsp_data_i,
  input  wire logic         spoll_valid_i,
  input  wire logic [7:0]   spoll_byte_i,
  // requests
  output logic              cmd_valid_o,
  output srq_pkg::srq_cmd_t cmd_o,
  output logic              dcl_o,
  output logic              spoll_o,
  output logic              rsp_take_o
);
  // idle request lines
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
    dcl_o = 1'b0;
    spoll_o = 1'b0;
    rsp_take_o = 1'b0;
  end
  // one command pulse, data inverted once released
  task automatic send(input srq_pkg::srq_op_t op, input logic [1:0] sel,
                      input logic [15:0] d, input logic first);
    @(posedge clock_i);
    cmd_o <= '{op, sel, d, first};
    cmd_valid_o <= 1'b1;
    @(posedge clock_i);
    cmd_valid_o <= 1'b0;
    cmd_o.data <= ~d;
  endtask
  // query, answer taken after a lag (slow controller)
  task automatic query(input srq_pkg::srq_op_t op, input logic [1:0] sel,
                       input int lag, output logic [15:0] q);
    send(op, sel, 16'h0000, 1'b0);
    #1;
    q = (rsp_valid_i === 1'b1) ? rsp_data_i : 16'hxxxx;
    repeat (lag) @(posedge clock_i);
    @(posedge clock_i);
    rsp_take_o <= 1'b1;
    @(posedge clock_i);
    rsp_take_o <= 1'b0;
  endtask
  // serial poll by interface message
  task automatic poll(output logic [7:0] b);
    @(posedge clock_i);
    spoll_o <= 1'b1;
    @(posedge clock_i);
    spoll_o <= 1'b0;
    #1;
    b = (spoll_valid_i === 1'b1) ? spoll_byte_i : 8'hxx;
  endtask
  // device clear message
  task automatic dev_clear();
    @(posedge clock_i);
    dcl_o <= 1'b1;
    @(posedge clock_i);
    dcl_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- sim/status_reporting_srq_tb.sv ----
// self-checking bench for the status reporting block
`timescale 1ns/1ps
`default_nettype none
module status_reporting_srq_tb;
  //------------------------------------------------------------
  // signals and instances
  //------------------------------------------------------------
  logic              clock_i = 1'b0;
  logic              resetn_i = 1'b0;
  logic              psc_i = 1'b1;
  logic              settings_busy_i = 1'b0;
  logic              if_overload_i = 1'b0;
  logic              err_push_i = 1'b0;
  logic [15:0]       err_code_i = 16'h0000;
  logic [15:0]       oper_cond_i = 16'h0000;
  logic [15:0]       ques_cond_i = 16'h0000;
  logic [15:0]       sync_cond_i = 16'h0000;
  logic [7:0]        esr_set_i = 8'h00;
  logic              cmd_valid_i, dcl_i, spoll_i, rsp_take_i;
  srq_pkg::srq_cmd_t cmd_i;
  logic              rsp_valid_o, spoll_valid_o, srq_o, flush_o;
  logic              overload_display_label_o, settings_reset_o;
  logic [15:0]       rsp_data_o, v;
  logic [7:0]        spoll_byte_o, pb;
  logic [15:0]       exp_q[$];
  int                num_errors = 0;
  int                num_checks = 0;
  // design with a recognisable saved request mask
  srq_status_reporting #(.ERR_DEPTH(8), .SAVED_SRE(8'h5A)) i_srq_status_reporting (
    .clock_i, .resetn_i, .psc_i, .cmd_valid_i, .cmd_i, .dcl_i, .spoll_i,
    .oper_cond_i, .ques_cond_i, .if_overload_i, .sync_cond_i, .esr_set_i,
    .settings_busy_i, .err_push_i, .err_code_i, .rsp_take_i, .rsp_valid_o,
    .rsp_data_o, .spoll_byte_o, .spoll_valid_o, .srq_o,
    .overload_display_label_o, .flush_o, .settings_reset_o);
  srq_ctrl_model i_srq_ctrl_model (
    .clock_i, .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
    .spoll_valid_i(spoll_valid_o), .spoll_byte_i(spoll_byte_o),
    .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .dcl_o(dcl_i),
    .spoll_o(spoll_i), .rsp_take_o(rsp_take_i));
  // 125 MHz clock
  initial begin
    forever #4 clock_i = ~clock_i;
  end
  //------------------------------------------------------------
  // expectations, compares and drivers
  //------------------------------------------------------------
  function automatic logic [15:0] msk(input logic [1:0] s);
    case (s)
      srq_pkg::REG_OPER: return srq_pkg::MASK_OPER;
      srq_pkg::REG_QUES: return srq_pkg::MASK_QUES;
      srq_pkg::REG_POW:  return srq_pkg::MASK_POW;
      default:           return srq_pkg::MASK_SYNC;
    endcase
  endfunction
  // oper and ques enables clear, the others fill
  function automatic logic [15:0] en_rst(input logic [1:0] s);
    return (s < 2'h2) ? 16'h0000 : msk(s);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkf(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rd(input srq_pkg::srq_op_t op, input logic [1:0] s,
                    input logic [15:0] exp);
    logic [15:0] q;
    i_srq_ctrl_model.query(op, s, $urandom_range(3), q);
    chk(q, exp);
  endtask
  task automatic wr(input srq_pkg::srq_op_t op, input logic [15:0] d);
    i_srq_ctrl_model.send(op, 2'h0, d, 1'b0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic push(input logic [15:0] c);
    @(posedge clock_i);
    err_push_i <= 1'b1;
    err_code_i <= c;
    @(posedge clock_i);
    err_push_i <= 1'b0;
  endtask
  task automatic power_on(input logic psc);
    @(posedge clock_i) resetn_i <= 1'b0;
    psc_i <= psc;
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
  endtask
  task automatic defaults();
    for (int s = 0; s < 4; s++) begin
      rd(srq_pkg::OP_RD_ENABLE, 2'(s), en_rst(2'(s)));
      rd(srq_pkg::OP_RD_PTR, 2'(s), msk(2'(s)));
      rd(srq_pkg::OP_RD_NTR, 2'(s), 16'h0000);
      rd(srq_pkg::OP_RD_EVENT, 2'(s), 16'h0000);
    end
  endtask
  task automatic end_of_test();
    $display("num_errors %0d num_checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog far beyond the expected run
  initial begin
    repeat (30000) @(posedge clock_i);
    num_errors++;
    end_of_test();
  end
  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  initial begin
    void'($urandom(32'he9ad_7cc4));
    power_on(1'b1);
    defaults();
    rd(srq_pkg::OP_RD_ESR, 2'h0, 16'h0080);
    rd(srq_pkg::OP_RD_SRE, 2'h0, 16'h0000);
    rd(srq_pkg::OP_RD_ERR, 2'h0, 16'h0000);
    // unused bits dropped, then preset restores
    for (int s = 0; s < 4; s++) begin
      v = 16'($urandom);
      i_srq_ctrl_model.send(srq_pkg::OP_WR_ENABLE, 2'(s), 16'hFFFF, 1'b0);
      i_srq_ctrl_model.send(srq_pkg::OP_WR_NTR, 2'(s), v, 1'b0);
      rd(srq_pkg::OP_RD_ENABLE, 2'(s), msk(2'(s)));
      rd(srq_pkg::OP_RD_NTR, 2'(s), v & msk(2'(s)));
    end
    wr(srq_pkg::OP_STAT_PRESET, 16'h0000);
    defaults();
    // overload flag, label, summary, clear on read
    @(posedge clock_i) if_overload_i <= 1'b1;
    wt(4);
    chkf(overload_display_label_o, 1'b1);
    rd(srq_pkg::OP_RD_COND, srq_pkg::REG_POW, 16'h0004);
    rd(srq_pkg::OP_RD_COND, srq_pkg::REG_QUES, 16'h0008);
    rd(srq_pkg::OP_RD_EVENT, srq_pkg::REG_POW, 16'h0004);
    rd(srq_pkg::OP_RD_EVENT, srq_pkg::REG_POW, 16'h0000);
    rd(srq_pkg::OP_RD_COND, srq_pkg::REG_POW, 16'h0004);
    rd(srq_pkg::OP_RD_COND, srq_pkg::REG_QUES, 16'h0000);
    @(posedge clock_i) if_overload_i <= 1'b0;
    wt(4);
    chkf(overload_display_label_o, 1'b0);
    // completion event raises a request via bit 5
    wr(srq_pkg::OP_WR_ESE, 16'h0001);
    wr(srq_pkg::OP_WR_SRE, 16'h0020);
    settings_busy_i <= 1'b1;
    wr(srq_pkg::OP_OPC, 16'h0000);
    wt(6);
    chkf(srq_o, 1'b0);
    @(posedge clock_i) settings_busy_i <= 1'b0;
    wt(6);
    chkf(srq_o, 1'b1);
    i_srq_ctrl_model.poll(pb);
    chk({8'h00, pb}, 16'h0060);
    rd(srq_pkg::OP_RD_STB, 2'h0, 16'h0060);
    wr(srq_pkg::OP_CLS, 16'h0000);
    wt(4);
    chkf(srq_o, 1'b0);
    rd(srq_pkg::OP_RD_ESR, 2'h0, 16'h0000);
    rd(srq_pkg::OP_RD_SRE, 2'h0, 16'h0020);
    // error queue fill past depth, device clear keeps it
    wr(srq_pkg::OP_WR_SRE, 16'h00FF);
    wr(srq_pkg::OP_WR_ESE, 16'h00FF);
    for (int i = 0; i < 9; i++) begin
      v = 16'($urandom) | 16'h0001;
      if (i < 8) exp_q.push_back(v);
      push(v);
    end
    wt(4);
    chkf(srq_o, 1'b1);
    i_srq_ctrl_model.dev_clear();
    #1;
    chkf(flush_o, 1'b1);
    while (exp_q.size() > 0) begin
      rd(srq_pkg::OP_RD_ERR, 2'h0, exp_q.pop_front());
    end
    rd(srq_pkg::OP_RD_ERR, 2'h0, 16'h0000);
    wt(4);
    chkf(srq_o, 1'b0);
    // pending answer cleared by device clear and new message
    i_srq_ctrl_model.send(srq_pkg::OP_RD_SRE, 2'h0, 16'h0000, 1'b0);
    i_srq_ctrl_model.dev_clear();
    #1;
    chkf(rsp_valid_o, 1'b0);
    rd(srq_pkg::OP_RD_SRE, 2'h0, 16'h00FF);
    i_srq_ctrl_model.send(srq_pkg::OP_RD_ESE, 2'h0, 16'h0000, 1'b0);
    i_srq_ctrl_model.send(srq_pkg::OP_RST, 2'h0, 16'h0000, 1'b1);
    #1;
    chkf(rsp_valid_o, 1'b0);
    chkf(settings_reset_o, 1'b1);
    // random condition levels read back through the masks
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_i);
      oper_cond_i <= 16'($urandom);
      ques_cond_i <= 16'($urandom);
      sync_cond_i <= 16'($urandom);
      wt(3);
      v = sync_cond_i & srq_pkg::MASK_SYNC;
      rd(srq_pkg::OP_RD_COND, srq_pkg::REG_SYNC, v);
      v = oper_cond_i & srq_pkg::MASK_OPER;
      rd(srq_pkg::OP_RD_COND, srq_pkg::REG_OPER, v);
    end
    // power-on without status clear empties queue and reloads the saved request mask
    push(16'h0123);
    power_on(1'b0);
    rd(srq_pkg::OP_RD_ERR, 2'h0, 16'h0000);
    rd(srq_pkg::OP_RD_SRE, 2'h0, 16'h005A);
    end_of_test();
  end
endmodule
`default_nettype wire
